// *** src/dpiol_top.sv ***
// dual port data latch: eight shared latches between a host bus and a user bus
// assumes all control and data pins are asynchronous to CLK_I; the bench
// resolves the two-way pins from the enables
`include "dpiol_regs.svh"

module dpiol_top
  import dpiol_pkg::*;
#(
  parameter int DATA_W     = `DPIOL_DATA_W,
  parameter int FIFO_DEPTH = `DPIOL_FIFO_DEPTH
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic              MASTER_CLK_I,
  input  wire logic              USER_INPUT_CTL_N_I,
  input  wire logic              USER_OUTPUT_CTL_N_I,
  input  wire logic              HOST_MASTER_ENABLE_N_I,
  input  wire logic              HOST_WRITE_CMD_I,
  input  wire logic              HOST_READ_CMD_N_I,
  input  wire logic [DATA_W-1:0] USER_DATA_LINES_I,
  output logic      [DATA_W-1:0] USER_DATA_LINES_O,
  output logic                   USER_DATA_LINES_OE_O,
  input  wire logic [DATA_W-1:0] HOST_BUS_LINES_I,
  output logic      [DATA_W-1:0] HOST_BUS_LINES_O,
  output logic                   HOST_BUS_LINES_OE_O,
  output logic                   BUF_FULL_O
);

  localparam int SW = 6 + 2 * DATA_W;
  localparam int QW = DATA_W + 1;

  // host bus drive decode
  function automatic logic host_drive(input logic me_n, input logic rd_n,
                                      input logic wr);
    host_drive = !me_n && !rd_n && !wr;
  endfunction : host_drive

  // user bus drive decode
  function automatic logic user_drive(input logic bic_n, input logic boc_n);
    user_drive = bic_n && !boc_n;
  endfunction : user_drive

  logic [SW-1:0]     meta_r;
  logic [SW-1:0]     sync_r;
  logic              mclk_s;
  logic              bic_n_s;
  logic              boc_n_s;
  logic              me_n_s;
  logic              wc_s;
  logic              rc_n_s;
  dpiol_byte_t       ud_s;
  dpiol_byte_t       hb_s;

  logic              user_cap;
  logic              host_cap;
  logic              any_cap;
  dpiol_wr_s         cap_word;
  logic              last_vld_r;
  dpiol_wr_s         last_r;
  logic              is_new;
  logic              push;
  logic              in_ready;

  logic [QW-1:0]     q_data;
  dpiol_wr_s         q_word;
  logic              q_valid;
  logic              q_ready;
  logic              pop;

  dpiol_byte_t       latch_r;
  dpiol_src_e        latch_src_r;

  // two flops on every pin before use
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      // controls rest at their idle levels so no false drive follows reset
      meta_r <= {`DPIOL_CTL_IDLE, {(2 * DATA_W){1'b0}}};
      sync_r <= {`DPIOL_CTL_IDLE, {(2 * DATA_W){1'b0}}};
    end else begin
      meta_r <= {MASTER_CLK_I, USER_INPUT_CTL_N_I, USER_OUTPUT_CTL_N_I,
                 HOST_MASTER_ENABLE_N_I, HOST_WRITE_CMD_I, HOST_READ_CMD_N_I,
                 USER_DATA_LINES_I, HOST_BUS_LINES_I};
      sync_r <= meta_r;
    end
  end

  assign {mclk_s, bic_n_s, boc_n_s, me_n_s, wc_s, rc_n_s, ud_s, hb_s} = sync_r;

  // user capture ignores the master enable
  assign user_cap = !bic_n_s && mclk_s;

  // host write needs enable, write, clock high and no user entry
  assign host_cap = !me_n_s && wc_s && mclk_s && bic_n_s;

  assign any_cap = user_cap || host_cap;

  // host data is stored inverted so each port reads its own value back
  always_comb begin
    if (user_cap) begin
      cap_word.src  = DPIOL_SRC_USER;
      cap_word.data = ud_s;
    end else begin
      cap_word.src  = DPIOL_SRC_HOST;
      cap_word.data = ~hb_s;
    end
  end

  // one queue entry per strobe or per change during a strobe
  assign is_new = !last_vld_r || (last_r != cap_word);
  assign push   = any_cap && is_new && in_ready;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      last_vld_r <= 1'b0;
      last_r     <= '0;
    end else if (!any_cap) begin
      last_vld_r <= 1'b0;
    end else if (push) begin
      last_vld_r <= 1'b1;
      last_r     <= cap_word;
    end
  end

  dpiol_fifo #(
    .W     (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_data_i   (cap_word),
    .in_valid_i  (any_cap && is_new),
    .in_ready_o  (in_ready),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (q_ready)
  );

  assign q_word = q_data;

  // latch is held steady while the host bus is being read
  assign q_ready = !HOST_BUS_LINES_OE_O;
  assign pop     = q_valid && q_ready;

  // the eight shared latches
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      latch_r     <= `DPIOL_LATCH_RST;
      latch_src_r <= DPIOL_SRC_USER;
    end else if (pop) begin
      latch_r     <= q_word.data;
      latch_src_r <= q_word.src;
    end
  end

  // user port driver, capture wins over output
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      USER_DATA_LINES_O    <= `DPIOL_USER_RST;
      USER_DATA_LINES_OE_O <= 1'b0;
    end else begin
      USER_DATA_LINES_O    <= latch_r;
      USER_DATA_LINES_OE_O <= user_drive(bic_n_s, boc_n_s);
    end
  end

  // host port driver, active low data
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HOST_BUS_LINES_O    <= `DPIOL_HOST_RST;
      HOST_BUS_LINES_OE_O <= 1'b0;
    end else begin
      HOST_BUS_LINES_O    <= ~latch_r;
      HOST_BUS_LINES_OE_O <= host_drive(me_n_s, rc_n_s, wc_s);
    end
  end

  // capture stalls while the buffer is full
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUF_FULL_O <= 1'b0;
    end else begin
      BUF_FULL_O <= !in_ready;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (RST_I);

  sequence host_wr_strobe;
    !me_n_s && wc_s && mclk_s;
  endsequence

  sequence host_wr_taken;
    push && cap_word.src == DPIOL_SRC_HOST;
  endsequence

  sequence latch_loaded;
    pop ##1 1'b1;
  endsequence

  sequence user_strobe;
    !bic_n_s && mclk_s;
  endsequence

  // user strobe enters the queue when room and new
  AST_USER_CAPTURE: assert property (
    (!bic_n_s && mclk_s && is_new && in_ready) |->
      push && cap_word.src == DPIOL_SRC_USER && cap_word.data == ud_s)
    else $error("user strobe not queued");

  // no user entry without the clock high
  AST_USER_NEEDS_CLK: assert property (
    (push && cap_word.src == DPIOL_SRC_USER) |-> mclk_s && !bic_n_s)
    else $error("user entry without strobe");

  // host write follows its strobe when the user side is idle
  AST_HOST_WRITE: assert property (
    (host_wr_strobe and bic_n_s && is_new && in_ready) |->
      host_wr_taken)
    else $error("host write not queued");

  // user entry blocks host writes
  AST_USER_PRIORITY: assert property (
    host_wr_taken |-> bic_n_s && !user_cap)
    else $error("host write during user entry");

  // disabled host side takes nothing and drives nothing
  AST_ME_BLOCKS: assert property (
    me_n_s |-> !host_cap ##1 !HOST_BUS_LINES_OE_O)
    else $error("host side active while disabled");

  // host drive follows the read decode one cycle later
  AST_HOST_DRIVE: assert property (
    (!me_n_s && !rc_n_s && !wc_s) |=> HOST_BUS_LINES_OE_O)
    else $error("host bus not driven on read");

  AST_HOST_IDLE: assert property (
    (rc_n_s || wc_s) |=> !HOST_BUS_LINES_OE_O)
    else $error("host bus driven without read");

  // user drive off during capture, on for output request
  AST_USER_OE: assert property (
    USER_DATA_LINES_OE_O == $past(bic_n_s && !boc_n_s))
    else $error("user drive enable wrong");

  AST_USER_OFF_ON_CAPTURE: assert property (
    !bic_n_s |=> !USER_DATA_LINES_OE_O)
    else $error("user drivers on during capture");

  // queued word reaches the latch one cycle later and both ports the cycle after
  AST_LATCH_LOAD: assert property (
    pop |=> latch_r == $past(q_word.data))
    else $error("latch not loaded");

  AST_PORT_POLARITY: assert property (
    latch_loaded |=>
      USER_DATA_LINES_O == $past(latch_r) &&
      HOST_BUS_LINES_O == ~$past(latch_r))
    else $error("port polarity wrong");

  // host writes read back unchanged on the host side
  AST_HOST_READBACK: assert property (
    (pop && q_word.src == DPIOL_SRC_HOST) |=> ##1
      HOST_BUS_LINES_O == ~$past(q_word.data, 2))
    else $error("host readback wrong");

  // latch stays put while the host reads it
  AST_READ_STABLE: assert property (
    HOST_BUS_LINES_OE_O |=> $stable(latch_r))
    else $error("latch moved during host read");

  // start state after reset
  AST_START_STATE: assert property (
    $past(RST_I) |-> USER_DATA_LINES_O == `DPIOL_USER_RST &&
      HOST_BUS_LINES_O == `DPIOL_HOST_RST && latch_r == `DPIOL_LATCH_RST)
    else $error("start state wrong");

  // both drivers released right after reset
  AST_START_RELEASED: assert property (
    $past(RST_I) |-> !USER_DATA_LINES_OE_O && !HOST_BUS_LINES_OE_O)
    else $error("driver on after reset");

  // user strobe always shuts out host capture
  AST_STROBE_BLOCKS_HOST: assert property (
    user_strobe |-> !host_cap)
    else $error("host capture during user strobe");

  // nothing is captured while the master clock is low
  AST_NO_CAP_CLK_LOW: assert property (
    !mclk_s |-> !any_cap)
    else $error("capture with master clock low");

  // host data enters the queue inverted
  AST_HOST_INVERT: assert property (
    host_wr_taken |-> cap_word.data == ~hb_s)
    else $error("host data not inverted");

  // latch only changes on a pop
  AST_LATCH_HOLD: assert property (
    !pop |=> $stable(latch_r))
    else $error("latch changed without pop");

  // user drivers idle when no output is asked for
  AST_USER_IDLE: assert property (
    (bic_n_s && boc_n_s) |=> !USER_DATA_LINES_OE_O)
    else $error("user drivers on while idle");

  // user output works with the host side disabled
  AST_USER_ME_FREE: assert property (
    (me_n_s && bic_n_s && !boc_n_s) |=> USER_DATA_LINES_OE_O)
    else $error("user output blocked by master enable");

  // full flag follows queue room one cycle later
  AST_FULL_FLAG: assert property (
    !in_ready |=> BUF_FULL_O)
    else $error("full flag missing");

endmodule : dpiol_top

// *** common/dpiol_regs.svh ***
// constants for the dual port data latch: widths, depths, reset values
// assumes inclusion by the package and the design files only
`ifndef DPIOL_REGS_SVH
`define DPIOL_REGS_SVH

`define DPIOL_DATA_W     8
`define DPIOL_FIFO_DEPTH 16
`define DPIOL_SYNC_W     22
`define DPIOL_LATCH_RST  8'hff
`define DPIOL_HOST_RST   8'h00
`define DPIOL_USER_RST   8'hff
`define DPIOL_CTL_IDLE   6'h1d

`endif

// *** common/dpiol_pkg.sv ***
// types shared by the dual port data latch design files
// assumes dpiol_regs.svh sits on the include path
`include "dpiol_regs.svh"

package dpiol_pkg;

  typedef logic [`DPIOL_DATA_W-1:0] dpiol_byte_t;

  // which port a queued latch write came from
  typedef enum logic {
    DPIOL_SRC_USER = 1'b0,
    DPIOL_SRC_HOST = 1'b1
  } dpiol_src_e;

  typedef struct packed {
    dpiol_src_e  src;
    dpiol_byte_t data;
  } dpiol_wr_s;

endpackage : dpiol_pkg

// *** src/dpiol_fifo.sv ***
// small fifo with registered read data and valid/ready on both sides
// assumes one clock and a synchronous active-high reset
module dpiol_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CW-1:0] count_r;
  logic          push;
  logic          load;

  assign in_ready_o = (count_r != CW'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign load       = (count_r != '0) && (!out_valid_o || out_ready_i);

  // storage writes
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  // pointers wrap at the configured depth
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (load) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
    end
  end

  // occupancy of the storage array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + CW'(push) - CW'(load);
    end
  end

  // registered output stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rptr_r];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule : dpiol_fifo

// *** tb/dpiol_far_end.sv ***
// far-end model: user equipment and host bus drivers, with wire resolution
// assumes requests change at the falling clock edge
module dpiol_far_end (
  input  wire logic       clk_i,
  input  wire logic       mclk_req_i,
  input  wire logic       u_drv_i,
  input  wire logic [7:0] u_val_i,
  input  wire logic       h_drv_i,
  input  wire logic [7:0] h_val_i,
  input  wire logic [7:0] u_dev_i,
  input  wire logic       u_oe_i,
  input  wire logic [7:0] h_dev_i,
  input  wire logic       h_oe_i,
  output logic            mclk_o,
  output logic      [7:0] u_wire_o,
  output logic      [7:0] h_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] u_last_r = 8'h00;
  logic [7:0] h_last_r = 8'h00;
  // master clock strobe supplied by the system side
  assign mclk_o = mclk_req_i;
  // released lines show a value that flips every cycle
  assign u_wire_o = u_oe_i ? u_dev_i : (u_drv_i ? u_val_i : ~u_last_r);
  assign h_wire_o = h_oe_i ? h_dev_i : (h_drv_i ? h_val_i : ~h_last_r);
  always_ff @(posedge clk_i) begin
    u_last_r <= u_wire_o;
    h_last_r <= h_wire_o;
  end
endmodule : dpiol_far_end

// *** tb/tb_dpiol_top.sv ***
// self-checking bench for the dual port data latch
// assumes the far-end model resolves both two-way buses
module tb_dpiol_top
  import dpiol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, mclk = 0, uic_n = 1, uoc_n = 1, me_n = 1;
  logic wc = 0, rc_n = 1, u_drv = 0, h_drv = 0;
  dpiol_byte_t u_val = 8'h00, h_val = 8'h00, u_w, h_w, u_o, h_o;
  logic mclk_w, u_oe, h_oe, full;
  int failures = 0, n_checks = 0, cycles = 0;

  always #12.5 clk = ~clk;

  dpiol_top i_dpiol_top (.CLK_I(clk), .RST_I(rst), .MASTER_CLK_I(mclk_w),
    .USER_INPUT_CTL_N_I(uic_n), .USER_OUTPUT_CTL_N_I(uoc_n),
    .HOST_MASTER_ENABLE_N_I(me_n), .HOST_WRITE_CMD_I(wc), .HOST_READ_CMD_N_I(rc_n),
    .USER_DATA_LINES_I(u_w), .USER_DATA_LINES_O(u_o), .USER_DATA_LINES_OE_O(u_oe),
    .HOST_BUS_LINES_I(h_w), .HOST_BUS_LINES_O(h_o), .HOST_BUS_LINES_OE_O(h_oe),
    .BUF_FULL_O(full));
  dpiol_far_end i_dpiol_far_end (.clk_i(clk), .mclk_req_i(mclk), .u_drv_i(u_drv),
    .u_val_i(u_val), .h_drv_i(h_drv), .h_val_i(h_val), .u_dev_i(u_o), .u_oe_i(u_oe),
    .h_dev_i(h_o), .h_oe_i(h_oe), .mclk_o(mclk_w), .u_wire_o(u_w), .h_wire_o(h_w));

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input dpiol_byte_t got, input dpiol_byte_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic uwr(input dpiol_byte_t d);
    @(negedge clk);
    u_val = d; u_drv = 1; uic_n = 0; mclk = 1;
    cyc(8);
    mclk = 0;
    cyc(1);
    uic_n = 1; u_drv = 0;
  endtask : uwr

  task automatic hwr(input dpiol_byte_t d);
    @(negedge clk);
    h_val = d; h_drv = 1; me_n = 0; wc = 1; mclk = 1;
    cyc(8);
    mclk = 0;
    cyc(1);
    wc = 0; h_drv = 0; me_n = 1;
  endtask : hwr

  task automatic urd(input dpiol_byte_t exp);
    @(negedge clk);
    uoc_n = 0;
    cyc(6);
    chk({7'h00, u_oe}, 8'h01, "user drive");
    chk(u_w, exp, "user read");
    uoc_n = 1;
    cyc(4);
  endtask : urd

  task automatic hrd(input dpiol_byte_t exp);
    @(negedge clk);
    me_n = 0; rc_n = 0;
    cyc(6);
    chk({7'h00, h_oe}, 8'h01, "host drive");
    chk(h_w, exp, "host read");
    rc_n = 1; me_n = 1;
    cyc(4);
  endtask : hrd

  task automatic t_reset();
    chk(u_o, 8'hff, "user start");
    chk(h_o, 8'h00, "host start");
    chk({6'h00, u_oe, h_oe}, 8'h00, "drivers off");
    chk({7'h00, full}, 8'h00, "full flag");
  endtask : t_reset

  task automatic t_user();
    uwr(8'ha5);
    urd(8'ha5);
    hrd(8'h5a);
  endtask : t_user

  task automatic t_mclk_low();
    @(negedge clk);
    u_val = 8'h0f; u_drv = 1; uic_n = 0; uoc_n = 0;
    cyc(8);
    chk({7'h00, u_oe}, 8'h00, "capture beats output");
    uic_n = 1; uoc_n = 1; u_drv = 0;
    cyc(4);
    urd(8'ha5);
  endtask : t_mclk_low

  task automatic t_host();
    hwr(8'h3c);
    hrd(8'h3c);
    urd(8'hc3);
  endtask : t_host

  task automatic t_prio();
    @(negedge clk);
    u_val = 8'h81; u_drv = 1; uic_n = 0;
    h_val = 8'h18; h_drv = 1; me_n = 0; wc = 1; mclk = 1;
    cyc(8);
    mclk = 0;
    cyc(1);
    uic_n = 1; u_drv = 0; wc = 0; h_drv = 0; me_n = 1;
    cyc(4);
    urd(8'h81);
  endtask : t_prio

  task automatic t_me_off();
    @(negedge clk);
    wc = 1; mclk = 1; h_val = 8'h77; h_drv = 1;
    cyc(8);
    mclk = 0;
    cyc(1);
    wc = 0; h_drv = 0; rc_n = 0;
    cyc(6);
    chk({7'h00, h_oe}, 8'h00, "disabled host drive");
    rc_n = 1;
    urd(8'h81);
    uwr(8'h42);
    urd(8'h42);
  endtask : t_me_off

  task automatic t_both();
    @(negedge clk);
    me_n = 0; uoc_n = 0;
    cyc(6);
    chk({7'h00, h_oe}, 8'h00, "read idle");
    rc_n = 0;
    cyc(6);
    chk({6'h00, u_oe, h_oe}, 8'h03, "both drive");
    chk(h_w, 8'hbd, "host side");
    chk(u_w, 8'h42, "user side");
    rc_n = 1; me_n = 1; uoc_n = 1;
    cyc(4);
  endtask : t_both

  task automatic t_fifo();
    int k;
    @(negedge clk);
    me_n = 0; rc_n = 0; u_drv = 1; uic_n = 0; mclk = 1;
    for (k = 1; k <= 40; k++) begin
      u_val = 8'(k);
      cyc(1);
    end
    chk({7'h00, full}, 8'h01, "queue full");
    chk(h_w, 8'hbd, "frozen during read");
    u_val = 8'he7; rc_n = 1; me_n = 1;
    k = 0;
    while (full !== 1'b0 && k < 100) begin
      cyc(1);
      k++;
    end
    chk({7'h00, full}, 8'h00, "queue drained");
    cyc(40);
    mclk = 0;
    cyc(1);
    uic_n = 1; u_drv = 0;
    urd(8'he7);
  endtask : t_fifo

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  initial begin
    cyc(8);
    rst = 0;
    cyc(3);
    t_reset();
    t_user();
    t_mclk_low();
    t_host();
    t_prio();
    t_me_off();
    t_both();
    t_fifo();
    final_report();
  end
endmodule : tb_dpiol_top
